// file: hw/tcp_pkg.sv
/*
  Shared constants and types of the timer, counter and PWM unit.
  Assumes word-aligned register access over a 32-bit AHB-Lite bus.
*/
`default_nettype none

package tcp_pkg;
  localparam int          CNT_W         = 16;
  localparam int          DEAD_W        = 8;
  localparam int          ST_W          = 3;
  localparam int          FAB_N         = 5;
  // Register byte offsets
  localparam logic [7:0]  OFF_CTRL      = 8'h00;
  localparam logic [7:0]  OFF_PERIOD    = 8'h04;
  localparam logic [7:0]  OFF_COMPARE   = 8'h08;
  localparam logic [7:0]  OFF_COUNT     = 8'h0C;
  localparam logic [7:0]  OFF_CAPTURE   = 8'h10;
  localparam logic [7:0]  OFF_STATUS    = 8'h14;
  localparam logic [7:0]  OFF_MASK      = 8'h18;
  localparam logic [7:0]  OFF_PRESCALE  = 8'h1C;
  // Control field positions
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_MODE_LSB = 1;
  localparam int          CTRL_CSEL_LSB = 3;
  localparam int          CTRL_REL_LSB  = 5;
  localparam int          CTRL_COMP_BIT = 8;
  localparam int          CTRL_DEAD_LSB = 16;
  localparam logic [31:0] CTRL_WMASK    = 32'h00FF_01FF;
  // Status bit positions
  localparam int          ST_TC         = 0;
  localparam int          ST_CAP        = 1;
  localparam int          ST_DONE       = 2;
  // Fabric input positions
  localparam int          FAB_CLK       = 0;
  localparam int          FAB_RST       = 1;
  localparam int          FAB_CAP       = 2;
  localparam int          FAB_EN        = 3;
  localparam int          FAB_KILL      = 4;
  // Reset values
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
  localparam logic [15:0] PERIOD_RST    = 16'hFFFF;
  localparam logic [15:0] COMPARE_RST   = 16'h8000;
  localparam logic [15:0] PRESCALE_RST  = 16'h0000;
  localparam logic [15:0] CNT_RST       = 16'h0000;

  typedef enum logic [1:0] {
    TCP_FREE    = 2'h0,
    TCP_ONESHOT = 2'h1,
    TCP_GATED   = 2'h2
  } tcp_mode_t;

  typedef enum logic [1:0] {
    CSEL_SYS    = 2'h0,
    CSEL_DIV    = 2'h1,
    CSEL_FABRIC = 2'h2
  } tcp_csel_t;

  typedef enum logic [2:0] {
    compare_less          = 3'h0,
    compare_less_equal    = 3'h1,
    compare_equal         = 3'h2,
    compare_greater_equal = 3'h3,
    compare_greater       = 3'h4
  } tcp_rel_t;

  typedef enum logic [1:0] {
    TCP_IDLE = 2'b01,
    TCP_RUN  = 2'b10
  } tcp_state_t;
endpackage : tcp_pkg

`default_nettype wire

// file: hw/tcp_pwm_if.sv
/*
  Link between the counter core and the deadband output stage.
  Assumes both ends run on clk_sys.
*/
`default_nettype none

interface tcp_pwm_if;
  import tcp_pkg::*;
  logic              cmp_raw;
  logic              kill;
  logic              comp_en;
  logic [DEAD_W-1:0] dead;
  logic              out_p;
  logic              out_n;
  modport core (output cmp_raw, output kill, output comp_en, output dead,
                input out_p, input out_n);
  modport gen  (input cmp_raw, input kill, input comp_en, input dead,
                output out_p, output out_n);
endinterface : tcp_pwm_if

`default_nettype wire

// file: hw/tcp_sync.sv
/*
  Three-stage synchronisers for the routing fabric inputs.
  Assumes inputs are asynchronous to clk_sys; output changes once
  stages two and three agree.
*/
`default_nettype none

module tcp_sync #(
  parameter int N = 5
) (
  input  wire logic         clk_sys, // System clock
  input  wire logic         reset,   // Async reset, high
  input  wire logic [N-1:0] din,     // Raw fabric levels
  output var  logic [N-1:0] dout     // Filtered levels
);
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      logic [2:0] sh_reg;
      logic [2:0] sh_next;
      logic       flt_next;
      always_comb begin
        sh_next  = {sh_reg[1:0], din[g]};
        flt_next = (sh_reg[1] == sh_reg[2]) ? sh_reg[2] : dout[g];
      end
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          sh_reg  <= 3'h0;
          dout[g] <= 1'b0;
        end else begin
          sh_reg  <= sh_next;
          dout[g] <= flt_next;
        end
      end
    end
  endgenerate
endmodule : tcp_sync

`default_nettype wire

// file: hw/tcp_dead.sv
/*
  Complementary output stage with deadband and kill override.
  Assumes compare level and kill arrive on clk_sys.
*/
`default_nettype none

module tcp_dead (
  input  wire logic clk_sys, // System clock
  input  wire logic reset,   // Async reset, high
  tcp_pwm_if.gen    pw       // Compare in, outputs back
);
  import tcp_pkg::*;

  logic              p_reg;
  logic              p_next;
  logic              n_reg;
  logic              n_next;
  logic [DEAD_W-1:0] dcnt_reg;
  logic [DEAD_W-1:0] dcnt_next;
  logic              prev_reg;

  always_comb begin
    p_next    = 1'b0;
    n_next    = 1'b0;
    dcnt_next = '0;
    if (!pw.comp_en) begin
      p_next = pw.cmp_raw & ~pw.kill; // RULE_11
    end else if (pw.kill) begin
      dcnt_next = pw.dead; // RULE_11
    end else if (pw.cmp_raw != prev_reg) begin
      dcnt_next = pw.dead; // RULE_10
    end else if (dcnt_reg != '0) begin
      dcnt_next = dcnt_reg - 1'b1; // RULE_10
    end else begin
      p_next = pw.cmp_raw;
      n_next = ~pw.cmp_raw; // RULE_03
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      p_reg    <= 1'b0;
      n_reg    <= 1'b0;
      dcnt_reg <= '0;
      prev_reg <= 1'b0;
    end else begin
      p_reg    <= p_next;
      n_reg    <= n_next;
      dcnt_reg <= dcnt_next;
      prev_reg <= pw.cmp_raw;
    end
  end

  assign pw.out_p = p_reg;
  assign pw.out_n = n_reg;

  a_no_overlap: assert property (@(posedge clk_sys) disable iff (reset) // RULE_10
    !(p_reg && n_reg)) else $error("both outputs active");
  a_kill_off: assert property (@(posedge clk_sys) disable iff (reset) // RULE_11
    pw.kill |=> !p_reg && !n_reg) else $error("output active under kill");
  a_dead_gap: assert property (@(posedge clk_sys) disable iff (reset) // RULE_10
    pw.comp_en && !pw.kill && (pw.cmp_raw != prev_reg) |=> !p_reg && !n_reg)
    else $error("no deadband after edge");
endmodule : tcp_dead

`default_nettype wire

// file: hw/tcp_top.sv
/*
  Timer, counter and PWM unit with AHB-Lite register slave.
  Assumes a single AHB-Lite master; fabric inputs are asynchronous.
*/
// Our own choices: the register addresses and the AHB-Lite slave port.
`default_nettype none

// Function
// (RULE_01) The counter is 16 bits wide and only ever counts down.
// (RULE_02) The count clock comes from one of several sources chosen by configuration.
// (RULE_03) The unit drives a compare output, a terminal count output and an optional complement.
// (RULE_04) Counting runs free, single-shot or gated by the enable input.
// (RULE_05) In gated mode the counter advances only while enable is high, else holds.
// (RULE_06) In single-shot mode the counter stops after one period.
// (RULE_07) The period is loaded on start, on the reset input and at terminal count.
// (RULE_08) A reset input and a capture input exist; capture latches the full counter.
// (RULE_09) Compare output uses a selectable less, less-equal, equal, greater-equal or greater test.
// (RULE_10) The complementary pair has a deadband so both are never active together.
// (RULE_11) While kill is high the compare-driven outputs are forced inactive.
// (RULE_12) All fabric inputs and outputs connect only through the routing fabric.
// (RULE_13) Terminal count pulses for one count-clock cycle at zero, before the reload.
// (RULE_14) Software reads the live counter without disturbing it.
module tcp_top (
  input  wire logic        clk_sys,       // 25 MHz system clock
  input  wire logic        reset,         // Async reset, high
  input  wire logic        hsel,          // Slave select
  input  wire logic [31:0] haddr,         // Byte address
  input  wire logic [1:0]  htrans,        // Transfer type
  input  wire logic        hwrite,        // Write when high
  input  wire logic [2:0]  hsize,         // Word only
  input  wire logic [31:0] hwdata,        // Write data
  input  wire logic        hready,        // Bus ready
  output var  logic [31:0] hrdata,        // Read data
  output var  logic        hreadyout,     // Slave ready
  output var  logic        hresp,         // Always OKAY
  input  wire logic        fab_count_clk, // Fabric count clock
  input  wire logic        fab_reset,     // Fabric timer reset
  input  wire logic        fab_capture,   // Fabric capture
  input  wire logic        fab_enable,    // Fabric count enable
  input  wire logic        fab_kill,      // Fabric output kill
  output var  logic        cmp_out,       // Compare output
  output var  logic        cmp_n_out,     // Complementary compare
  output var  logic        tc_out,        // Terminal count
  output var  logic        irq            // Interrupt level
);
  import tcp_pkg::*;

  logic [FAB_N-1:0] fab_raw;
  logic [FAB_N-1:0] fab_lvl;
  logic [FAB_N-1:0] fab_prev_reg;
  logic [FAB_N-1:0] fab_rise;

  logic [7:0]       addr_reg;
  logic [7:0]       addr_next;
  logic             wr_reg;
  logic             wr_next;
  logic             act_reg;
  logic             act_next;
  logic             hready_next;
  logic [31:0]      hrdata_next;
  logic [31:0]      rd_mux;
  logic             acc;
  logic             wr_stb;
  logic             rd_stb;

  logic [31:0]      ctrl_reg;
  logic [31:0]      ctrl_next;
  logic [CNT_W-1:0] period_reg;
  logic [CNT_W-1:0] period_next;
  logic [CNT_W-1:0] compare_reg;
  logic [CNT_W-1:0] compare_next;
  logic [CNT_W-1:0] prescale_reg;
  logic [CNT_W-1:0] prescale_next;
  logic [ST_W-1:0]  status_reg;
  logic [ST_W-1:0]  status_next;
  logic [ST_W-1:0]  mask_reg;
  logic [ST_W-1:0]  mask_next;
  logic             irq_next;

  tcp_state_t       state_reg;
  tcp_state_t       state_next;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [CNT_W-1:0] capture_reg;
  logic [CNT_W-1:0] capture_next;
  logic [CNT_W-1:0] div_reg;
  logic [CNT_W-1:0] div_next;
  logic             en_prev_reg;
  logic             tc_next;

  logic             en_bit;
  tcp_mode_t        mode;
  tcp_csel_t        csel;
  tcp_rel_t         rel;
  logic             div_tick;
  logic             src_tick;
  logic             cnt_tick;
  logic             start_evt;
  logic             rst_evt;
  logic             cap_evt;
  logic             load_evt;
  logic             tc_evt;
  logic             done_evt;
  logic             cmp_raw;

  tcp_pwm_if pw ();

  // Fabric inputs synchronised here; nothing bypasses the fabric
  assign fab_raw = {fab_kill, fab_enable, fab_capture, fab_reset, fab_count_clk}; // RULE_12

  tcp_sync #(.N(FAB_N)) u_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .din     (fab_raw),
    .dout    (fab_lvl)
  );

  assign fab_rise = fab_lvl & ~fab_prev_reg;

  // Configuration fields
  assign en_bit = ctrl_reg[CTRL_EN_BIT];
  assign mode   = tcp_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]); // RULE_04
  assign csel   = tcp_csel_t'(ctrl_reg[CTRL_CSEL_LSB +: 2]);
  assign rel    = tcp_rel_t'(ctrl_reg[CTRL_REL_LSB +: 3]);

  // Bus handshake: one wait state per transfer
  assign acc    = hsel & hready & htrans[1] & hreadyout;
  assign wr_stb = act_reg & wr_reg;
  assign rd_stb = act_reg & ~wr_reg;

  always_comb begin
    act_next    = acc;
    addr_next   = acc ? haddr[7:0] : addr_reg;
    wr_next     = acc ? hwrite : wr_reg;
    hready_next = ~acc;
    hrdata_next = rd_stb ? rd_mux : hrdata;
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_reg == OFF_CTRL) begin
      rd_mux = ctrl_reg;
    end else if (addr_reg == OFF_PERIOD) begin
      rd_mux = {16'h0000, period_reg};
    end else if (addr_reg == OFF_COMPARE) begin
      rd_mux = {16'h0000, compare_reg};
    end else if (addr_reg == OFF_COUNT) begin
      rd_mux = {16'h0000, count_reg}; // RULE_14
    end else if (addr_reg == OFF_CAPTURE) begin
      rd_mux = {16'h0000, capture_reg};
    end else if (addr_reg == OFF_STATUS) begin
      rd_mux = {29'h0000_0000, status_reg};
    end else if (addr_reg == OFF_MASK) begin
      rd_mux = {29'h0000_0000, mask_reg};
    end else if (addr_reg == OFF_PRESCALE) begin
      rd_mux = {16'h0000, prescale_reg};
    end
  end

  // Register writes and status
  always_comb begin
    ctrl_next     = ctrl_reg;
    period_next   = period_reg;
    compare_next  = compare_reg;
    mask_next     = mask_reg;
    prescale_next = prescale_reg;
    if (wr_stb) begin
      if (addr_reg == OFF_CTRL) begin
        ctrl_next = hwdata & CTRL_WMASK;
      end else if (addr_reg == OFF_PERIOD) begin
        period_next = hwdata[15:0];
      end else if (addr_reg == OFF_COMPARE) begin
        compare_next = hwdata[15:0];
      end else if (addr_reg == OFF_MASK) begin
        mask_next = hwdata[ST_W-1:0];
      end else if (addr_reg == OFF_PRESCALE) begin
        prescale_next = hwdata[15:0];
      end
    end
    // Read clears; a same-cycle event still sets
    status_next = status_reg;
    if (rd_stb && addr_reg == OFF_STATUS) begin
      status_next = '0;
    end
    status_next[ST_TC]   = status_next[ST_TC] | tc_evt;
    status_next[ST_CAP]  = status_next[ST_CAP] | cap_evt;
    status_next[ST_DONE] = status_next[ST_DONE] | done_evt;
    irq_next = |(status_next & mask_next);
  end

  // Count clock source
  assign div_tick = (div_reg == prescale_reg);
  assign div_next = div_tick ? CNT_RST : div_reg + 16'h0001;

  always_comb begin
    case (csel)
      CSEL_SYS:    src_tick = 1'b1; // RULE_02
      CSEL_DIV:    src_tick = div_tick; // RULE_02
      CSEL_FABRIC: src_tick = fab_rise[FAB_CLK]; // RULE_02
      default:     src_tick = 1'b0;
    endcase
  end

  assign start_evt = en_bit & ~en_prev_reg;
  assign rst_evt   = fab_rise[FAB_RST]; // RULE_08
  assign cap_evt   = fab_rise[FAB_CAP]; // RULE_08
  assign load_evt  = start_evt | rst_evt;
  assign cnt_tick  = (state_reg == TCP_RUN) & en_bit & src_tick
                   & ((mode != TCP_GATED) | fab_lvl[FAB_EN]); // RULE_05
  assign tc_evt    = cnt_tick & ~rst_evt & (count_reg == CNT_RST);
  assign done_evt  = tc_evt & (mode == TCP_ONESHOT);

  // Counter state machine
  always_comb begin
    state_next   = state_reg;
    count_next   = count_reg;
    capture_next = cap_evt ? count_reg : capture_reg; // RULE_08
    case (state_reg)
      TCP_IDLE: begin
        if (load_evt) begin
          count_next = period_reg; // RULE_07
          if (en_bit) begin
            state_next = TCP_RUN;
          end
        end
      end
      TCP_RUN: begin
        if (!en_bit) begin
          state_next = TCP_IDLE;
        end else if (rst_evt) begin
          count_next = period_reg; // RULE_07
        end else if (tc_evt) begin
          count_next = period_reg; // RULE_07
          if (mode == TCP_ONESHOT) begin
            state_next = TCP_IDLE; // RULE_06
          end
        end else if (cnt_tick) begin
          count_next = count_reg - 16'h0001; // RULE_01
        end
      end
      default: begin
        state_next = TCP_IDLE;
      end
    endcase
    tc_next = (state_next == TCP_RUN) && (count_next == CNT_RST); // RULE_13
  end

  // Compare relation
  always_comb begin
    case (rel)
      compare_less:          cmp_raw = count_reg <  compare_reg; // RULE_09
      compare_less_equal:    cmp_raw = count_reg <= compare_reg; // RULE_09
      compare_equal:         cmp_raw = count_reg == compare_reg; // RULE_09
      compare_greater_equal: cmp_raw = count_reg >= compare_reg; // RULE_09
      compare_greater:       cmp_raw = count_reg >  compare_reg; // RULE_09
      default:               cmp_raw = 1'b0;
    endcase
  end

  assign pw.cmp_raw = cmp_raw;
  assign pw.kill    = fab_lvl[FAB_KILL]; // RULE_11
  assign pw.comp_en = ctrl_reg[CTRL_COMP_BIT]; // RULE_03
  assign pw.dead    = ctrl_reg[CTRL_DEAD_LSB +: DEAD_W]; // RULE_10

  tcp_dead u_dead (
    .clk_sys (clk_sys),
    .reset   (reset),
    .pw      (pw)
  );

  assign cmp_out   = pw.out_p; // RULE_03
  assign cmp_n_out = pw.out_n; // RULE_03

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fab_prev_reg <= '0;
      addr_reg     <= 8'h00;
      wr_reg       <= 1'b0;
      act_reg      <= 1'b0;
      hreadyout    <= 1'b1;
      hrdata       <= 32'h0000_0000;
      hresp        <= 1'b0;
      ctrl_reg     <= CTRL_RST;
      period_reg   <= PERIOD_RST;
      compare_reg  <= COMPARE_RST;
      prescale_reg <= PRESCALE_RST;
      status_reg   <= '0;
      mask_reg     <= '0;
      irq          <= 1'b0;
      state_reg    <= TCP_IDLE;
      count_reg    <= CNT_RST;
      capture_reg  <= CNT_RST;
      div_reg      <= CNT_RST;
      en_prev_reg  <= 1'b0;
      tc_out       <= 1'b0;
    end else begin
      fab_prev_reg <= fab_lvl;
      addr_reg     <= addr_next;
      wr_reg       <= wr_next;
      act_reg      <= act_next;
      hreadyout    <= hready_next;
      hrdata       <= hrdata_next;
      hresp        <= 1'b0;
      ctrl_reg     <= ctrl_next;
      period_reg   <= period_next;
      compare_reg  <= compare_next;
      prescale_reg <= prescale_next;
      status_reg   <= status_next;
      mask_reg     <= mask_next;
      irq          <= irq_next;
      state_reg    <= state_next;
      count_reg    <= count_next;
      capture_reg  <= capture_next;
      div_reg      <= div_next;
      en_prev_reg  <= en_bit;
      tc_out       <= tc_next;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_end_of_period;
    (state_reg == TCP_RUN) && en_bit && tc_evt;
  endsequence

  a_count_down: assert property ( // RULE_01
    cnt_tick && !rst_evt && count_reg != 16'h0000 |=> count_reg == $past(count_reg) - 16'h0001)
    else $error("counter did not step down by one");
  a_gate_hold: assert property ( // RULE_05
    mode == TCP_GATED && !fab_lvl[FAB_EN] && !load_evt |=> $stable(count_reg))
    else $error("gated counter moved without enable");
  a_sys_source: assert property ( // RULE_02
    state_reg == TCP_RUN && en_bit && csel == CSEL_SYS && mode == TCP_FREE |-> cnt_tick)
    else $error("system source did not tick");
  a_period_reload: assert property ( // RULE_07
    s_end_of_period |=> count_reg == $past(period_reg))
    else $error("no period reload at terminal count");
  a_oneshot_stop: assert property ( // RULE_06
    s_end_of_period ##0 mode == TCP_ONESHOT |=> state_reg == TCP_IDLE [*2])
    else $error("single-shot did not stop");
  a_capture_val: assert property ( // RULE_08
    cap_evt |=> capture_reg == $past(count_reg))
    else $error("capture value wrong");
  a_tc_zero: assert property ( // RULE_13
    tc_out |-> count_reg == 16'h0000 && state_reg == TCP_RUN)
    else $error("terminal count away from zero");
  a_cmp_equal: assert property ( // RULE_09
    rel == compare_equal && !fab_lvl[FAB_KILL] |-> cmp_raw == (count_reg == compare_reg))
    else $error("equal relation wrong");
  a_live_read: assert property ( // RULE_14
    rd_stb && addr_reg == OFF_COUNT |=> hrdata[15:0] == $past(count_reg) && hreadyout)
    else $error("live counter read wrong");
  a_kill_outs: assert property ( // RULE_11
    fab_lvl[FAB_KILL] |=> !cmp_out && !cmp_n_out)
    else $error("outputs active under kill");
endmodule : tcp_top

`default_nettype wire

// file: testbench/tcp_fab_model.sv
/*
  Fabric-side logic model that drives the timer's routed inputs.
  Assumes the bench calls its tasks; every change follows a clk_sys edge.
*/
`default_nettype none

module tcp_fab_model (
  input  wire logic clk_sys, // System clock
  output var  logic cnt_clk, // Count clock
  output var  logic trst,    // Timer reset
  output var  logic cap,     // Capture
  output var  logic en,      // Enable level
  output var  logic kill     // Kill level
);
  timeunit 1ns;
  timeprecision 1ns;
  import tcp_pkg::*;
  logic [FAB_N-1:0] f = '0;
  assign {kill, en, cap, trst, cnt_clk} = f;

  task automatic lev(input int i, input logic v);
    @(posedge clk_sys);
    f[i] <= v;
  endtask : lev

  // Held well past the synchroniser so no edge is missed
  task automatic pulse(input int i);
    lev(i, 1'b1);
    repeat (4) @(posedge clk_sys);
    lev(i, 1'b0);
    repeat (4) @(posedge clk_sys);
  endtask : pulse
endmodule : tcp_fab_model

`default_nettype wire

// file: testbench/timer_counter_pwm_unit_tb.sv
/*
  Self-checking bench of the timer, counter and PWM unit.
  Assumes the one-wait-state AHB-Lite slave and fabric model beside it.
*/
`default_nettype none

module timer_counter_pwm_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tcp_pkg::*;
  logic        clk_sys = 0, reset = 1, hsel = 0, hwrite = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, r, s;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, cmp_out, cmp_n_out, tc_out, irq;
  logic        fc, fr, fp, fe, fk;
  int          failures = 0, num_checks = 0, n;

  tcp_top dut (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .fab_count_clk(fc), .fab_reset(fr), .fab_capture(fp), .fab_enable(fe),
    .fab_kill(fk), .cmp_out(cmp_out), .cmp_n_out(cmp_n_out), .tc_out(tc_out),
    .irq(irq));
  tcp_fab_model u_fab (.clk_sys(clk_sys), .cnt_clk(fc), .trst(fr), .cap(fp),
    .en(fe), .kill(fk));

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask : chk

  task automatic hwait;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      end_sim();
    end
  endtask : hwait

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hwait();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    hwait();
    r = hrdata;
  endtask : ahb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk($sformatf("reg_%h", a), e, r);
  endtask : rd

  function automatic logic [31:0] cf(input logic [1:0] m, input logic [1:0] cs,
                                     input logic [2:0] rl, input logic cp,
                                     input logic [7:0] dd);
    return 32'h1 | (m << CTRL_MODE_LSB) | (cs << CTRL_CSEL_LSB)
         | (rl << CTRL_REL_LSB) | (cp << CTRL_COMP_BIT) | (dd << CTRL_DEAD_LSB);
  endfunction : cf

  task automatic wtc;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (tc_out !== 1'b1 && n < 500);
    chk("tc_seen", 1, tc_out);
  endtask : wtc

  // Both outputs of the pair must never be high together
  always @(posedge clk_sys) begin
    if (cmp_out === 1'b1 && cmp_n_out === 1'b1) chk("pair_overlap", 0, 1);
  end

  task automatic t_reset;
    logic [7:0] z [5] = '{OFF_CTRL, OFF_COUNT, OFF_CAPTURE, OFF_STATUS, 8'h20};
    foreach (z[i]) rd(z[i], 0);
    rd(OFF_PERIOD, PERIOD_RST);
    rd(OFF_COMPARE, COMPARE_RST);
    chk("outs", {CNT_RST < COMPARE_RST, 4'h0}, {cmp_out, cmp_n_out, tc_out, irq, hresp});
  endtask : t_reset

  task automatic t_free;
    ahb(1, OFF_PERIOD, 3);
    ahb(1, OFF_CTRL, cf(TCP_FREE, CSEL_SYS, 0, 0, 0));
    wtc();
    @(posedge clk_sys);
    chk("tc_width", 0, tc_out);
    wtc();
    chk("tc_period", 4, n + 1);
    rd(OFF_COUNT, 2);
    chk("count_range", 1, r <= 3);
    ahb(1, OFF_CTRL, 0);
    ahb(0, OFF_STATUS, 0);
  endtask : t_free

  task automatic t_oneshot;
    ahb(1, OFF_MASK, 32'h4);
    ahb(1, OFF_PERIOD, 5);
    ahb(1, OFF_CTRL, cf(TCP_ONESHOT, CSEL_SYS, 0, 0, 0));
    wtc();
    repeat (20) @(posedge clk_sys);
    rd(OFF_COUNT, 5);
    chk("irq_set", 1, irq);
    ahb(1, OFF_MASK, 0);
    chk("irq_masked", 0, irq);
    ahb(1, OFF_MASK, 32'h4);
    chk("irq_unmask", 1, irq);
    rd(OFF_STATUS, 5);
    @(posedge clk_sys);
    chk("irq_clear", 0, irq);
    rd(OFF_STATUS, 0);
  endtask : t_oneshot

  task automatic t_gated;
    ahb(1, OFF_CTRL, 0);
    ahb(1, OFF_PERIOD, 10);
    ahb(1, OFF_CTRL, cf(TCP_GATED, CSEL_SYS, 0, 0, 0));
    repeat (10) @(posedge clk_sys);
    rd(OFF_COUNT, 10);
    u_fab.pulse(FAB_CAP);
    rd(OFF_CAPTURE, 10);
    u_fab.lev(FAB_EN, 1);
    repeat (3) @(posedge clk_sys);
    u_fab.lev(FAB_EN, 0);
    repeat (8) @(posedge clk_sys);
    ahb(0, OFF_COUNT, 0);
    s = r;
    rd(OFF_COUNT, s);
    chk("count_moved", 1, s < 10);
    u_fab.pulse(FAB_RST);
    rd(OFF_COUNT, 10);
  endtask : t_gated

  task automatic t_compare;
    logic e;
    for (int rl = 0; rl < 5; rl++)
      for (int v = 9; v < 12; v++) begin
        ahb(1, OFF_COMPARE, v);
        ahb(1, OFF_CTRL, cf(TCP_GATED, CSEL_SYS, rl, 0, 0));
        repeat (4) @(posedge clk_sys);
        e = rl == 0 ? 10 < v : rl == 1 ? 10 <= v : rl == 2 ? 10 == v
          : rl == 3 ? 10 >= v : 10 > v;
        chk($sformatf("cmp_rel%0d_%0d", rl, v), e, cmp_out);
      end
    // Compare true before kill so the override is visible
    ahb(1, OFF_CTRL, cf(TCP_GATED, CSEL_SYS, compare_less, 0, 0));
    u_fab.lev(FAB_KILL, 1);
    repeat (8) @(posedge clk_sys);
    chk("cmp_killed", 0, cmp_out);
    u_fab.lev(FAB_KILL, 0);
    repeat (8) @(posedge clk_sys);
    chk("cmp_unkill", 1, cmp_out);
    ahb(1, OFF_CTRL, cf(TCP_GATED, CSEL_SYS, compare_less, 1, 4));
    repeat (20) @(posedge clk_sys);
    chk("pair_hi", 2'b10, {cmp_out, cmp_n_out});
    ahb(1, OFF_COMPARE, 10);
    n = 0;
    repeat (20) begin
      @(posedge clk_sys);
      n += (cmp_out | cmp_n_out) === 1'b0;
    end
    chk("dead_gap", 5, n);
    chk("pair_lo", 2'b01, {cmp_out, cmp_n_out});
  endtask : t_compare

  task automatic t_fabclk;
    ahb(1, OFF_CTRL, 0);
    ahb(1, OFF_PERIOD, 7);
    ahb(1, OFF_CTRL, cf(TCP_FREE, CSEL_FABRIC, 0, 0, 0));
    repeat (4) u_fab.pulse(FAB_CLK);
    rd(OFF_COUNT, 3);
    // Prescaler source: tick every PRESCALE+1 clocks
    ahb(1, OFF_PRESCALE, 1);
    ahb(1, OFF_CTRL, 0);
    ahb(1, OFF_CTRL, cf(TCP_FREE, CSEL_DIV, 0, 0, 0));
    wtc();
    repeat (2) @(posedge clk_sys);
    wtc();
    chk("div_period", 16, n + 2);
  endtask : t_fabclk

  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_free();
    t_oneshot();
    t_gated();
    t_compare();
    t_fabclk();
    end_sim();
  end
endmodule : timer_counter_pwm_unit_tb

`default_nettype wire
